// file: verilog/gpo_port.sv
// Eight-pin general-purpose I/O port with AXI4-Lite register access.
//
// Notes on behaviour
// - Input pull-up is on only for dir 0, data 1, kill 0.
// - Direction bit one makes the pin an output, zero an input.
// - Output pins drive the output data bit value.
// - Reset tri-states every pin asynchronously, clock or not.
// - Pull-up kill disables every pull-up at once.
// - Synchronized pin level is readable whatever the direction.
// - Sync latch transparent while clock high, then registered on rising edge.
// - Written output value appears at pin input two clocks later.
// - Sleep clamps the digital input to ground.
// - Pins with external interrupt enabled are not clamped.
// - Clamp-caused change on wake sets the interrupt flag for high pins.
// - Pull-up stays off during reset.
// - Pull-up override forces the pull-up to the override value.
// - Direction override controls the driver enable.
// - Value override sets the driven value when the driver is on.
// - Toggle override inverts the output data bit.
// - Input-enable override beats the sleep state.
// - Alternate digital input taken before the synchronizer.
// - Writing ones to pin input register toggles output data bits.
//
// Register window is sixteen bytes; higher addresses answer SLVERR.
// Only byte lane 0 is wired; writes without it are acknowledged and dropped.
// Overrides are plain inputs: tie them low where no peripheral shares a pin.
// Pin input reads lag the pad by the synchronizer, so software waits one slot.
`timescale 1ns/100ps

module gpo_port (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // AXI4-Lite write address
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Pads
    input  wire logic [7:0]  pad_in,
    output logic      [7:0]  pad_out,
    output logic      [7:0]  pad_oe_n,
    output logic      [7:0]  pad_pullup,
    // Sleep controller
    input  wire logic        sleep,
    input  wire logic [7:0]  ext_irq_en,
    // Alternate-function overrides
    input  wire logic [7:0]  pullup_ovr_en,
    input  wire logic [7:0]  pullup_ovr_val,
    input  wire logic [7:0]  dir_ovr_en,
    input  wire logic [7:0]  dir_ovr_val,
    input  wire logic [7:0]  val_ovr_en,
    input  wire logic [7:0]  val_ovr_val,
    input  wire logic [7:0]  toggle_ovr_en,
    input  wire logic [7:0]  din_ovr_en,
    input  wire logic [7:0]  din_ovr_val,
    // Alternate digital input and wake events
    output logic      [7:0]  alt_digital_in,
    output logic      [7:0]  wake_edge_evt
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    // Software-visible port bits
    logic [7:0]  dir_reg;
    logic [7:0]  out_data_reg;
    logic        pullup_kill_reg;
    // Pad path: synchronized level, Schmitt output and per-pin controls
    logic [7:0]  pin_in_bit;
    logic [7:0]  schmitt_out;
    logic [7:0]  drive_en;
    logic [7:0]  drive_val;
    logic [7:0]  pullup_en;
    logic [7:0]  din_en;
    logic [7:0]  din_en_reg;
    logic [7:0]  pad_level;
    // Bus bookkeeping
    logic [31:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        aw_held;
    logic        w_held;
    logic        wr_fire;
    logic [3:0]  wr_ofs;
    logic [3:0]  rd_ofs;
    logic [7:0]  pin_toggle;

    // ------------------------------------------------------------
    // Pad control
    // ------------------------------------------------------------
    // Overrides pass straight through, so all-zero overrides leave plain GPIO
    gpo_pin_logic u_pin (
        .dir_bit        (dir_reg),
        .out_data_bit   (out_data_reg),
        .pullup_kill    (pullup_kill_reg),
        .pullup_ovr_en  (pullup_ovr_en),
        .pullup_ovr_val (pullup_ovr_val),
        .dir_ovr_en     (dir_ovr_en),
        .dir_ovr_val    (dir_ovr_val),
        .val_ovr_en     (val_ovr_en),
        .val_ovr_val    (val_ovr_val),
        .din_ovr_en     (din_ovr_en),
        .din_ovr_val    (din_ovr_val),
        .ext_irq_en     (ext_irq_en),
        .sleep          (sleep),
        .drive_en       (drive_en),
        .drive_val      (drive_val),
        .pullup_en      (pullup_en),
        .din_en         (din_en)
    );

    // Pad outputs registered; reset forces tri-state, no pull-up
    // Pull-up follows its own enable only, so an override may hold it while driving
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pad_oe_n   <= 8'hFF;
            pad_out    <= 8'h00;
            pad_pullup <= 8'h00;
        end else begin
            pad_oe_n   <= ~drive_en;
            pad_out    <= drive_val;
            pad_pullup <= pullup_en;
        end
    end

    // Clamp to ground at the Schmitt input when input disabled
    // A disabled input reads zero, so a floating pad cannot toggle the logic
    assign pad_level   = pad_in;
    assign schmitt_out = pad_level & din_en;

    // ------------------------------------------------------------
    // Input synchronizer
    // ------------------------------------------------------------
    // Half a cycle in the latch, then the rising-edge register
    gpo_sync_latch u_sync (
        .clk   (clk),
        .rst   (rst),
        .d_in  (schmitt_out),
        .q_out (pin_in_bit)
    );

    // Alternate digital input and wake-up clamp release detection
    // Enable history resets to all-on so leaving reset raises no wake event
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            alt_digital_in <= 8'h00;
            din_en_reg     <= 8'hFF;
            wake_edge_evt  <= 8'h00;
        end else begin
            alt_digital_in <= schmitt_out;
            din_en_reg     <= din_en;
            // Clamp release with high pad looks like a rising edge
            wake_edge_evt  <= din_en & ~din_en_reg & pad_in;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign wr_ofs  = awaddr_reg[3:0];

    // Capture address and data in either order
    // Each ready pulses one cycle; a held half waits for its partner
    // A standing response blocks the next write so none is lost
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            awaddr_reg    <= gpo_pkg::DATA_ZERO;
            wdata_reg     <= gpo_pkg::DATA_ZERO;
            wstrb_reg     <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held    <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held    <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    // Write response
    // Response stands until bready is seen high
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= gpo_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_reg[31:4] == 28'h000_0000)
                ? gpo_pkg::RESP_OKAY : gpo_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Port registers
    // ------------------------------------------------------------
    assign pin_toggle = (wr_fire && wstrb_reg[0] && awaddr_reg[31:4] == 28'h000_0000
        && wr_ofs == gpo_pkg::OFS_PIN_IN) ? wdata_reg[7:0] : 8'h00;

    // Direction, output data and pull-up kill
    // Toggle override acts on every cycle it stands, a data write included
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dir_reg         <= gpo_pkg::PORT_RESET_VAL;
            out_data_reg    <= gpo_pkg::PORT_RESET_VAL;
            pullup_kill_reg <= 1'b0;
        end else begin
            if (wr_fire && wstrb_reg[0] && awaddr_reg[31:4] == 28'h000_0000) begin
                case (wr_ofs)
                    gpo_pkg::OFS_DIR:     dir_reg <= wdata_reg[7:0];
                    gpo_pkg::OFS_CONTROL: pullup_kill_reg <=
                        wdata_reg[gpo_pkg::CTL_PULLUP_KILL_BIT];
                    default: ;
                endcase
            end
            // Data write, then pin-register toggles and peripheral toggles
            if (wr_fire && wstrb_reg[0] && awaddr_reg[31:4] == 28'h000_0000
                && wr_ofs == gpo_pkg::OFS_OUT_DATA) begin
                out_data_reg <= wdata_reg[7:0] ^ toggle_ovr_en;
            end else begin
                out_data_reg <= out_data_reg ^ pin_toggle ^ toggle_ovr_en;
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    assign rd_ofs = s_axi_araddr[3:0];

    // One read in flight; answer the cycle after acceptance
    // Arready is withheld while an answer still stands
    // Pin input reads return the level one synchronizer delay old
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= gpo_pkg::DATA_ZERO;
            s_axi_rresp   <= gpo_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= gpo_pkg::RESP_OKAY;
                s_axi_rdata  <= gpo_pkg::DATA_ZERO;
                if (s_axi_araddr[31:4] != 28'h000_0000) begin
                    s_axi_rresp <= gpo_pkg::RESP_SLVERR;
                end else begin
                    case (rd_ofs)
                        gpo_pkg::OFS_PIN_IN:   s_axi_rdata[7:0] <= pin_in_bit;
                        gpo_pkg::OFS_DIR:      s_axi_rdata[7:0] <= dir_reg;
                        gpo_pkg::OFS_OUT_DATA: s_axi_rdata[7:0] <= out_data_reg;
                        gpo_pkg::OFS_CONTROL: begin
                            s_axi_rdata[gpo_pkg::CTL_PULLUP_KILL_BIT] <= pullup_kill_reg;
                            s_axi_rdata[gpo_pkg::CTL_SLEEP_BIT]       <= sleep;
                        end
                        default: s_axi_rresp <= gpo_pkg::RESP_SLVERR;
                    endcase
                end
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// file: verilog/gpo_pkg.sv
// Package for the general-purpose port block: register map, field positions, reset values.
package gpo_pkg;

    // ------------------------------------------------------------
    // Port geometry
    // ------------------------------------------------------------
    localparam int NUM_PINS = 8;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_PIN_IN   = 4'h0;  // Read pin level, write ones toggle data
    localparam logic [3:0] OFS_DIR      = 4'h4;  // Direction bits
    localparam logic [3:0] OFS_OUT_DATA = 4'h8;  // Output data / pull-up select
    localparam logic [3:0] OFS_CONTROL  = 4'hC;  // Pull-up kill and sleep status

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CTL_PULLUP_KILL_BIT = 0;
    localparam int CTL_SLEEP_BIT       = 1;
    localparam logic [7:0] PORT_RESET_VAL = 8'h00;
    localparam logic [31:0] DATA_ZERO     = 32'h0000_0000;

    // ------------------------------------------------------------
    // AXI responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: verilog/gpo_sync_latch.sv
// Input synchronizer: clock-high transparent latch followed by a rising-edge register.
`timescale 1ns/100ps

module gpo_sync_latch (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Data
    input  wire logic [7:0] d_in,
    output logic      [7:0] q_out
);

    logic [7:0] latch_q;

    // Latch transparent while clock is high, holds on falling edge
    always_latch begin
        if (clk) begin
            latch_q <= d_in;
        end
    end

    // Register the latched value on the next rising edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q_out <= gpo_pkg::PORT_RESET_VAL;
        end else begin
            q_out <= latch_q;
        end
    end

endmodule

// file: verilog/gpo_pin_logic.sv
// Per-pin combinational pad control with alternate-function overrides.
`timescale 1ns/100ps

module gpo_pin_logic (
    // Register bits
    input  wire logic [7:0] dir_bit,
    input  wire logic [7:0] out_data_bit,
    input  wire logic       pullup_kill,
    // Overrides
    input  wire logic [7:0] pullup_ovr_en,
    input  wire logic [7:0] pullup_ovr_val,
    input  wire logic [7:0] dir_ovr_en,
    input  wire logic [7:0] dir_ovr_val,
    input  wire logic [7:0] val_ovr_en,
    input  wire logic [7:0] val_ovr_val,
    input  wire logic [7:0] din_ovr_en,
    input  wire logic [7:0] din_ovr_val,
    input  wire logic [7:0] ext_irq_en,
    input  wire logic       sleep,
    // Results
    output logic      [7:0] drive_en,
    output logic      [7:0] drive_val,
    output logic      [7:0] pullup_en,
    output logic      [7:0] din_en
);

    genvar i;
    generate
        for (i = 0; i < gpo_pkg::NUM_PINS; i++) begin : g_pin
            // Pull-up: override, else only for {dir,data,kill} = 010
            assign pullup_en[i] = pullup_ovr_en[i] ? pullup_ovr_val[i]
                : (!dir_bit[i] && out_data_bit[i] && !pullup_kill);
            // Driver enable: override or direction bit
            assign drive_en[i]  = dir_ovr_en[i] ? dir_ovr_val[i] : dir_bit[i];
            // Driven value: override or data bit
            assign drive_val[i] = val_ovr_en[i] ? val_ovr_val[i] : out_data_bit[i];
            // Input enable: override, else off in sleep unless interrupt enabled
            assign din_en[i]    = din_ovr_en[i] ? din_ovr_val[i]
                : (!sleep || ext_irq_en[i]);
        end
    endgenerate

endmodule

// file: tb/gpo_port_properties.sv
// Concurrent checks on the pad and alternate-function pins of the port block.
`timescale 1ns/100ps

module gpo_port_properties (
    // Clock, reset and sleep
    input wire logic       clk, rst, sleep,
    // Pads and wake
    input wire logic [7:0] pad_in, pad_out, pad_oe_n, pad_pullup, ext_irq_en,
    input wire logic [7:0] alt_digital_in, wake_edge_evt,
    // Overrides
    input wire logic [7:0] pullup_ovr_en, pullup_ovr_val, dir_ovr_en, dir_ovr_val,
    input wire logic [7:0] val_ovr_en, val_ovr_val, din_ovr_en, din_ovr_val
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Pads released and pull-ups off right up to reset release
    AST_RESET_RELEASE: assert property ($fell(rst) |-> pad_oe_n == 8'hff && pad_pullup == 8'h00)
        else $error("pads not released during reset");
    AST_PULLUP_OVR: assert property (pullup_ovr_en == 8'hff |=> pad_pullup == $past(pullup_ovr_val))
        else $error("pull-up ignores override");
    AST_DIR_OVR: assert property (dir_ovr_en == 8'hff |=> pad_oe_n == ~$past(dir_ovr_val))
        else $error("driver enable ignores override");
    AST_VAL_OVR: assert property (val_ovr_en == 8'hff |=>
        (pad_out & ~pad_oe_n) == ($past(val_ovr_val) & ~pad_oe_n))
        else $error("driven value ignores override");
    AST_NO_PULL_DRIVE: assert property (pullup_ovr_en == 8'h00 && dir_ovr_en == 8'h00 |=>
        (pad_pullup & ~pad_oe_n) == 8'h00)
        else $error("pull-up on a driven pin");
    AST_SLEEP_CLAMP: assert property (sleep && ext_irq_en == 8'h00 && din_ovr_en == 8'h00 |=>
        alt_digital_in == 8'h00)
        else $error("input not clamped in sleep");
    // Past reset is skipped: the first sample after release still holds the reset value
    AST_CLAMP_MASK: assert property (!$past(rst) && din_ovr_en == 8'h00 |=>
        alt_digital_in == ($past(pad_in) & ($past(ext_irq_en) | {8{!$past(sleep)}})))
        else $error("clamp mask wrong");
    AST_DIN_OVR: assert property (!$past(rst) && din_ovr_en == 8'hff |=>
        alt_digital_in == ($past(pad_in) & $past(din_ovr_val)))
        else $error("input enable ignores override");
    AST_WAKE_PULSE: assert property (wake_edge_evt != 8'h00 |=> wake_edge_evt == 8'h00)
        else $error("wake event longer than one cycle");
endmodule

bind gpo_port gpo_port_properties u_gpo_port_properties (
    .clk, .rst, .sleep, .pad_in, .pad_out, .pad_oe_n, .pad_pullup, .ext_irq_en,
    .alt_digital_in, .wake_edge_evt, .pullup_ovr_en, .pullup_ovr_val, .dir_ovr_en,
    .dir_ovr_val, .val_ovr_en, .val_ovr_val, .din_ovr_en, .din_ovr_val
);

// file: tb/gpo_pad_env.sv
// Pad-side circuitry: resolves each pad from device driver, external driver and pull-up.
`timescale 1ns/100ps

module gpo_pad_env (
    // Clock
    input wire logic       clk,
    // Device side and external driver
    input wire logic [7:0] pad_out, pad_oe_n, pad_pullup, ext_en, ext_val,
    // Level seen at the pads
    output logic     [7:0] pad_in
);
    logic [7:0] float_q = 8'h00;

    // Undriven pads flip every cycle so no stale level passes
    always_ff @(posedge clk) float_q <= ~float_q;

    // Device driver first, then external driver, then pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pad_in[i] = !pad_oe_n[i] ? pad_out[i] : ext_en[i] ? ext_val[i] :
                        pad_pullup[i] ? 1'b1 : float_q[i];
        end
    end
endmodule

// file: tb/gpo_port_bench.sv
// Self-checking bench for the eight-pin port with its pad-side model.
`timescale 1ns/100ps

module gpo_port_bench;
    logic        clk = 1'b0, rst = 1'b1, sleep = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0000_0000, s_axi_wdata = 32'h0000_0000;
    logic [31:0] s_axi_araddr = 32'h0000_0000, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [7:0]  pad_in, pad_out, pad_oe_n, pad_pullup, alt_digital_in, wake_edge_evt;
    logic [7:0]  ext_irq_en = 8'h00, pullup_ovr_en = 8'h00, pullup_ovr_val = 8'h00;
    logic [7:0]  dir_ovr_en = 8'h00, dir_ovr_val = 8'h00, val_ovr_en = 8'h00;
    logic [7:0]  val_ovr_val = 8'h00, toggle_ovr_en = 8'h00, din_ovr_en = 8'h00;
    logic [7:0]  din_ovr_val = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
    int          errors = 0, n_tests = 0;
    logic [27:0] addr_hi = 28'h000_0000;

    gpo_port u_gpo_port (.*);
    gpo_pad_env u_gpo_pad_env (.clk, .pad_out, .pad_oe_n, .pad_pullup, .ext_en, .ext_val,
                               .pad_in);

    always #50 clk = ~clk;

    // Verdict and end of run
    task automatic complete_run;
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Bus write: ready and response sampled mid-cycle, taken at the next rising edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic ta, tw, tb;
        @(posedge clk);
        s_axi_awaddr <= {addr_hi, a};
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(negedge clk);
            ta = s_axi_awready;
            tw = s_axi_wready;
            tb = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) begin
                s_axi_bready <= 1'b0;
                return;
            end
        end
        errors++;
        complete_run;
    endtask

    task automatic rdr(input logic [3:0] a);
        logic ta, tr;
        @(posedge clk);
        s_axi_araddr <= {addr_hi, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(negedge clk);
            ta = s_axi_arready;
            tr = s_axi_rvalid;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge clk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr) begin
                s_axi_rready <= 1'b0;
                return;
            end
        end
        errors++;
        complete_run;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        rdr(a);
        chk(rd[7:0], e);
    endtask

    // Write one register, let pads settle, judge direction, pull-up and drive
    task automatic step(input logic [3:0] a, input logic [7:0] v, d, o, k);
        wr(a, v);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(pad_oe_n, ~d);
        chk(pad_pullup, ~d & o & ~k);
        chk(pad_out & d, o & d);
    endtask

    task automatic t_modes;
        rchk(gpo_pkg::OFS_DIR, 8'h00);
        rchk(gpo_pkg::OFS_OUT_DATA, 8'h00);
        rchk(gpo_pkg::OFS_CONTROL, 8'h00);
        // Path 00, 01, 11, 10, 00 never jumps across the opposite state
        step(gpo_pkg::OFS_OUT_DATA, 8'hff, 8'h00, 8'hff, 8'h00);
        rchk(gpo_pkg::OFS_PIN_IN, 8'hff);
        step(gpo_pkg::OFS_DIR, 8'hff, 8'hff, 8'hff, 8'h00);
        step(gpo_pkg::OFS_OUT_DATA, 8'h00, 8'hff, 8'h00, 8'h00);
        rchk(gpo_pkg::OFS_PIN_IN, 8'h00);
        step(gpo_pkg::OFS_DIR, 8'h00, 8'h00, 8'h00, 8'h00);
        step(gpo_pkg::OFS_OUT_DATA, 8'hff, 8'h00, 8'hff, 8'h00);
        step(gpo_pkg::OFS_CONTROL, 8'h01, 8'h00, 8'hff, 8'hff);
        rchk(gpo_pkg::OFS_CONTROL, 8'h01);
        step(gpo_pkg::OFS_CONTROL, 8'h00, 8'h00, 8'hff, 8'h00);
        $display("modes test done");
    endtask

    task automatic t_toggle;
        wr(gpo_pkg::OFS_PIN_IN, 8'h3c);
        rchk(gpo_pkg::OFS_OUT_DATA, 8'hc3);
        @(posedge clk);
        toggle_ovr_en <= 8'h0f;
        @(posedge clk);
        toggle_ovr_en <= 8'h00;
        rchk(gpo_pkg::OFS_OUT_DATA, 8'hcc);
        $display("toggle test done");
    endtask

    task automatic t_ovr;
        @(posedge clk);
        pullup_ovr_en <= 8'hff;
        pullup_ovr_val <= 8'h81;
        dir_ovr_en <= 8'hff;
        dir_ovr_val <= 8'h0f;
        val_ovr_en <= 8'hff;
        val_ovr_val <= 8'h55;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(pad_pullup, 8'h81);
        chk(pad_oe_n, 8'hf0);
        chk(pad_out & 8'h0f, 8'h05);
        @(posedge clk);
        pullup_ovr_en <= 8'h00;
        dir_ovr_en <= 8'h00;
        val_ovr_en <= 8'h00;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(pad_oe_n, 8'hff);
        chk(pad_pullup, 8'hcc);
        $display("override test done");
    endtask

    task automatic t_input;
        wr(gpo_pkg::OFS_DIR, 8'hff);
        wr(gpo_pkg::OFS_OUT_DATA, 8'h5a);
        rchk(gpo_pkg::OFS_PIN_IN, 8'h5a);
        wr(gpo_pkg::OFS_DIR, 8'h00);
        @(posedge clk);
        ext_en <= 8'hff;
        ext_val <= 8'ha5;
        rchk(gpo_pkg::OFS_PIN_IN, 8'ha5);
        $display("input test done");
    endtask

    task automatic t_sleep;
        int n;
        @(posedge clk);
        ext_val <= 8'hff;
        sleep <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(alt_digital_in, 8'h00);
        @(posedge clk);
        ext_irq_en <= 8'h0f;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(alt_digital_in, 8'h0f);
        @(posedge clk);
        din_ovr_en <= 8'hff;
        din_ovr_val <= 8'h3c;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(alt_digital_in, 8'h3c);
        @(posedge clk);
        din_ovr_en <= 8'h00;
        ext_irq_en <= 8'h00;
        repeat (2) @(posedge clk);
        sleep <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (n < 6 && wake_edge_evt !== 8'hff);
        chk(wake_edge_evt, 8'hff);
        @(negedge clk);
        chk(alt_digital_in, 8'hff);
        $display("sleep test done");
    endtask

    // Accesses above the register window are refused and change nothing
    task automatic t_bus;
        addr_hi = 28'h000_0001;
        wr(gpo_pkg::OFS_DIR, 8'h77);
        chk(8'(rsp), 8'(gpo_pkg::RESP_SLVERR));
        rdr(gpo_pkg::OFS_DIR);
        chk(8'(rsp), 8'(gpo_pkg::RESP_SLVERR));
        addr_hi = 28'h000_0000;
        rchk(gpo_pkg::OFS_DIR, 8'h00);
        chk(8'(rsp), 8'(gpo_pkg::RESP_OKAY));
        $display("bus test done");
    endtask

    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(pad_oe_n, 8'hff);
        chk(pad_pullup, 8'h00);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_modes;
        t_toggle;
        t_ovr;
        t_input;
        t_sleep;
        t_bus;
        complete_run;
    end
endmodule
